// ==== src/adc_irq_pkg.sv ====
// Purpose: shared constants for the converter event flag and enable registers
// Assumes: 16-bit register words, register port addressed by word offset
// Notes:   one place for every offset, bit position and reset value
package adc_irq_pkg;

	// ==========================================================
	// widths
	localparam int REG_W      = 16;
	localparam int FLAG_W     = 13;
	localparam int ADDR_W     = 8;
	localparam int NUM_COMP   = 4;
	localparam int FLAG_PAD_W = REG_W - FLAG_W;

	// ==========================================================
	// register offsets
	localparam logic [ADDR_W-1:0] ADDR_INTERRUPT_FLAGS = 8'h12;
	localparam logic [ADDR_W-1:0] ADDR_INTERRUPT_MASK  = 8'h13;

	// ==========================================================
	// flag and enable bit positions (same layout in both registers)
	localparam int BIT_CYCLE_DONE_FLAG       = 12;
	localparam int BIT_CONVERTER_FAULT_FLAG  = 11;
	localparam int BIT_FIELD_LOSS_FLAG       = 10;
	localparam int BIT_FRAME_ERROR_FLAG      = 9;
	localparam int BIT_CHECKSUM_ERROR_FLAG   = 8;
	localparam int BIT_COMPARATOR_RISE_LSB   = 4;
	localparam int BIT_COMPARATOR_FALL_LSB   = 0;

	// ==========================================================
	// reset values
	localparam logic [FLAG_W-1:0] FLAGS_RESET   = 13'h0000;
	localparam logic [FLAG_W-1:0] MASK_RESET    = 13'h0000;
	localparam logic [REG_W-1:0]  RDDATA_RESET  = 16'h0000;
	localparam logic [NUM_COMP-1:0] COMP_RESET  = 4'h0;

	// ==========================================================
	// address decode, used by the read and the write path
	function automatic logic isReg(
		input logic [ADDR_W-1:0] addr,
		input logic [ADDR_W-1:0] offset
	);
		return addr == offset;
	endfunction

endpackage

// ==== src/flag_bus_if.sv ====
// Purpose: carries set, clear and state of the sticky flag bank
// Assumes: all signals on ref_clk
// Notes:   owner holds the flags, user drives the events
interface flag_bus_if;
	import adc_irq_pkg::*;

	logic [FLAG_W-1:0] setVec;
	logic              clrAll;
	logic [FLAG_W-1:0] flags;

	modport owner (
		input  setVec,
		input  clrAll,
		output flags
	);

	modport user (
		output setVec,
		output clrAll,
		input  flags
	);

endinterface

// ==== src/sticky_flag_bank.sv ====
// Purpose: bank of sticky event flags, cleared all at once
// Assumes: set and clear are single-cycle strobes or levels on ref_clk
// Notes:   a set in the clearing cycle survives the clear
module sticky_flag_bank
	import adc_irq_pkg::*;
(
	input  wire logic ref_clk,
	input  wire logic srst,
	flag_bus_if.owner fb
);

	// ==========================================================
	// flag storage
	logic [FLAG_W-1:0] flags_r;
	logic [FLAG_W-1:0] flags_nxt;

	genvar gi;
	generate
		for (gi = 0; gi < FLAG_W; gi++) begin : gBit
			// set wins so an event during a read is never lost
			assign flags_nxt[gi] = fb.setVec[gi] |
				(flags_r[gi] & ~fb.clrAll);
		end
	endgenerate

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			flags_r <= FLAGS_RESET;
		end else begin
			flags_r <= flags_nxt;
		end
	end

	assign fb.flags = flags_r;

	// ==========================================================
	// checks
	AST_SET_BEATS_CLEAR:
	assert property (@(posedge ref_clk) disable iff (srst)
		fb.clrAll |=> (flags_r == $past(fb.setVec)))
	else $error("clear did not leave exactly the same-cycle events");

	AST_FLAGS_HOLD:
	assert property (@(posedge ref_clk) disable iff (srst)
		!fb.clrAll |=> ((flags_r & $past(flags_r)) == $past(flags_r)))
	else $error("flag dropped without a clear");

endmodule // sticky_flag_bank

// ==== src/adc_event_interrupt_regs.sv ====
// Purpose: event flags, enables and interrupt line of a four-channel
//          isolated converter, on the device register port
// Assumes: register port and all event inputs run on ref_clk
// Notes:   read data registered, one cycle after the read strobe
//
// Contract
// - a completed four-channel conversion cycle sets flag bit 12.
// - an out-of-range converter diagnostic sets flag bit 11.
// - a loss of field-side data sets flag bit 10.
// - a malformed serial frame sets flag bit 9 until a status read.
// - a serial CRC failure sets flag bit 8 until a status read.
// - a rise of comparator four..one sets flag bit 7..4.
// - a fall of comparator four..one sets flag bit 3..0.
// - any status read clears every flag not set in that same cycle, and all flags reset to zero.
// - enable bit 12 gates the conversion-cycle interrupt.
// - enable bit 11 gates the converter fault interrupt.
// - enable bit 10 gates the field loss interrupt.
// - enable bit 9 gates the frame error interrupt.
// - enable bit 8 gates the CRC error interrupt.
// - enable bits 7..5 gate the rises of comparators four..two.
// - enable bit 4 gates the rise of comparator one.
// - enable bits 3..0 gate the falls of comparators four..one.
module adc_event_interrupt_regs
	import adc_irq_pkg::*;
(
	input  wire logic                ref_clk,
	input  wire logic                srst,
	input  wire logic [ADDR_W-1:0]   regAddr,
	input  wire logic                regWrEn,
	input  wire logic                regRdEn,
	input  wire logic [REG_W-1:0]    regWrData,
	output logic      [REG_W-1:0]    regRdData,
	output logic                     regRdValid,
	input  wire logic                cycleDone,
	input  wire logic                convFault,
	input  wire logic                fieldLoss,
	input  wire logic                frameError,
	input  wire logic                checksumError,
	input  wire logic [NUM_COMP-1:0] thresholdOutputPin,
	output logic                     irqOut
);

	// ==========================================================
	// flag bank
	flag_bus_if flagBus ();

	sticky_flag_bank uFlagBank (
		.ref_clk (ref_clk),
		.srst    (srst),
		.fb      (flagBus)
	);

	logic [FLAG_W-1:0] flagsNow;
	assign flagsNow = flagBus.flags;

	// ==========================================================
	// register decode
	logic statusSel;
	logic maskSel;
	logic statusRead;
	logic maskWrite;

	assign statusSel  = isReg(regAddr, ADDR_INTERRUPT_FLAGS);
	assign maskSel    = isReg(regAddr, ADDR_INTERRUPT_MASK);
	assign statusRead = regRdEn & statusSel;
	// the status register ignores writes
	assign maskWrite  = regWrEn & maskSel;

	// ==========================================================
	// comparator edge detection
	logic [NUM_COMP-1:0] compPrev_r;
	logic                primed_r;
	logic [NUM_COMP-1:0] riseVec;
	logic [NUM_COMP-1:0] fallVec;

	// first cycle after reset has no history, so no edge is counted
	assign riseVec = primed_r ? (thresholdOutputPin & ~compPrev_r)
		: COMP_RESET;
	assign fallVec = primed_r ? (~thresholdOutputPin & compPrev_r)
		: COMP_RESET;

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			compPrev_r <= COMP_RESET;
			primed_r   <= 1'b0;
		end else begin
			compPrev_r <= thresholdOutputPin;
			primed_r   <= 1'b1;
		end
	end

	// ==========================================================
	// event collection
	assign flagBus.setVec = {
		cycleDone,
		convFault,
		fieldLoss,
		frameError,
		checksumError,
		riseVec,
		fallVec
	};
	assign flagBus.clrAll = statusRead;

	// ==========================================================
	// enable register
	logic [FLAG_W-1:0] mask_r;
	logic [FLAG_W-1:0] mask_nxt;

	assign mask_nxt = maskWrite ? regWrData[FLAG_W-1:0] : mask_r;

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			mask_r <= MASK_RESET;
		end else begin
			mask_r <= mask_nxt;
		end
	end

	// ==========================================================
	// read path
	logic [REG_W-1:0] rdData_r;
	logic [REG_W-1:0] rdData_nxt;
	logic [REG_W-1:0] rdMux;
	logic             rdValid_r;

	// unmapped offsets read as zero, upper bits always zero
	assign rdMux = statusSel ? {{FLAG_PAD_W{1'b0}}, flagsNow}
		: maskSel ? {{FLAG_PAD_W{1'b0}}, mask_r}
		: RDDATA_RESET;
	assign rdData_nxt = regRdEn ? rdMux : rdData_r;

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			rdData_r  <= RDDATA_RESET;
			rdValid_r <= 1'b0;
		end else begin
			rdData_r  <= rdData_nxt;
			rdValid_r <= regRdEn;
		end
	end

	assign regRdData  = rdData_r;
	assign regRdValid = rdValid_r;

	// ==========================================================
	// interrupt line
	logic [FLAG_W-1:0] pending;
	logic              irq_r;

	assign pending = flagsNow & mask_r;

	// registered so the pin never glitches on a mask write
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			irq_r <= 1'b0;
		end else begin
			irq_r <= |pending;
		end
	end

	assign irqOut = irq_r;

	// ==========================================================
	// checks
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (srst);

	AST_CYCLE_DONE_SET:
	assert property (cycleDone |=> flagsNow[BIT_CYCLE_DONE_FLAG])
	else $error("cycle done event not flagged");

	AST_CYCLE_DONE_CAUSE:
	assert property ($rose(flagsNow[BIT_CYCLE_DONE_FLAG])
		|-> $past(cycleDone))
	else $error("cycle done flag rose without an event");

	AST_CONV_FAULT_SET:
	assert property (convFault |=> flagsNow[BIT_CONVERTER_FAULT_FLAG])
	else $error("converter fault not flagged");

	AST_CONV_FAULT_CAUSE:
	assert property ($rose(flagsNow[BIT_CONVERTER_FAULT_FLAG])
		|-> $past(convFault))
	else $error("converter fault flag rose while in range");

	AST_FIELD_LOSS_SET:
	assert property (fieldLoss |=> flagsNow[BIT_FIELD_LOSS_FLAG])
	else $error("field data loss not flagged");

	AST_FIELD_LOSS_CAUSE:
	assert property ($rose(flagsNow[BIT_FIELD_LOSS_FLAG])
		|-> $past(fieldLoss))
	else $error("field loss flag rose without a loss");

	AST_FRAME_ERR_HOLD:
	assert property (frameError ##1 (!statusRead [*2])
		|-> flagsNow[BIT_FRAME_ERROR_FLAG])
	else $error("frame error flag not held until a read");

	AST_FRAME_ERR_CAUSE:
	assert property ($rose(flagsNow[BIT_FRAME_ERROR_FLAG])
		|-> $past(frameError))
	else $error("frame error flag rose without an error");

	AST_CRC_ERR_HOLD:
	assert property (checksumError ##1 (!statusRead [*2])
		|-> flagsNow[BIT_CHECKSUM_ERROR_FLAG])
	else $error("crc error flag not held until a read");

	AST_CRC_ERR_CAUSE:
	assert property ($rose(flagsNow[BIT_CHECKSUM_ERROR_FLAG])
		|-> $past(checksumError))
	else $error("crc error flag rose without an error");

	AST_RISE_SET:
	assert property (primed_r && $rose(thresholdOutputPin[NUM_COMP-1])
		|=> flagsNow[BIT_COMPARATOR_RISE_LSB+NUM_COMP-1])
	else $error("comparator four rise not flagged");

	AST_RISE_ALL:
	assert property ((riseVec != COMP_RESET) |=>
		((flagsNow[7:4] & $past(riseVec)) == $past(riseVec)))
	else $error("comparator rise landed on the wrong bit");

	AST_FALL_SET:
	assert property (primed_r && $fell(thresholdOutputPin[0])
		|=> flagsNow[BIT_COMPARATOR_FALL_LSB])
	else $error("comparator one fall not flagged");

	AST_FALL_ALL:
	assert property ((fallVec != COMP_RESET) |=>
		((flagsNow[3:0] & $past(fallVec)) == $past(fallVec)))
	else $error("comparator fall landed on the wrong bit");

	AST_READ_CLEARS:
	assert property (statusRead && (flagBus.setVec == FLAGS_RESET)
		|=> (flagsNow == FLAGS_RESET))
	else $error("status read did not clear the flags");

	AST_READ_RETURNS:
	assert property (statusRead |=> (regRdValid &&
		regRdData == {{FLAG_PAD_W{1'b0}}, $past(flagsNow)}))
	else $error("status read returned the wrong word");

	AST_CYCLE_GATED:
	assert property (flagsNow[BIT_CYCLE_DONE_FLAG] &&
		mask_r[BIT_CYCLE_DONE_FLAG] |=> irqOut)
	else $error("enabled cycle done flag gave no interrupt");

	AST_FAULT_GATED:
	assert property (flagsNow[BIT_CONVERTER_FAULT_FLAG] &&
		mask_r[BIT_CONVERTER_FAULT_FLAG] |=> irqOut)
	else $error("enabled converter fault gave no interrupt");

	AST_LOSS_GATED:
	assert property (flagsNow[BIT_FIELD_LOSS_FLAG] &&
		mask_r[BIT_FIELD_LOSS_FLAG] |=> irqOut)
	else $error("enabled field loss gave no interrupt");

	AST_FRAME_GATED:
	assert property (flagsNow[BIT_FRAME_ERROR_FLAG] &&
		mask_r[BIT_FRAME_ERROR_FLAG] |=> irqOut)
	else $error("enabled frame error gave no interrupt");

	AST_CRC_GATED:
	assert property (flagsNow[BIT_CHECKSUM_ERROR_FLAG] &&
		mask_r[BIT_CHECKSUM_ERROR_FLAG] |=> irqOut)
	else $error("enabled crc error gave no interrupt");

	AST_RISE_HIGH_GATED:
	assert property (((flagsNow[7:5] & mask_r[7:5]) != 3'h0) |=> irqOut)
	else $error("enabled upper comparator rise gave no interrupt");

	AST_RISE_ONE_GATED:
	assert property (flagsNow[BIT_COMPARATOR_RISE_LSB] &&
		mask_r[BIT_COMPARATOR_RISE_LSB] |=> irqOut)
	else $error("enabled comparator one rise gave no interrupt");

	AST_FALL_GATED:
	assert property (((flagsNow[3:0] & mask_r[3:0]) != 4'h0) |=> irqOut)
	else $error("enabled comparator fall gave no interrupt");

	AST_MASKED_QUIET:
	assert property (((flagsNow & mask_r) == FLAGS_RESET) |=> !irqOut)
	else $error("interrupt raised with nothing enabled and pending");

	AST_IRQ_DROPS_AFTER_READ:
	assert property (statusRead && (flagBus.setVec == FLAGS_RESET)
		##1 (flagBus.setVec == FLAGS_RESET) |=> !irqOut)
	else $error("interrupt stayed high after the flags were read");

	AST_MASK_WRITE:
	assert property (maskWrite |=> (mask_r == $past(regWrData[FLAG_W-1:0])))
	else $error("enable register write not stored");

	AST_UNMAPPED_ZERO:
	assert property (regRdEn && !statusSel && !maskSel
		|=> (regRdData == RDDATA_RESET))
	else $error("unmapped offset read nonzero");

endmodule // adc_event_interrupt_regs

// ==== tb/reg_host_model.sv ====
// Purpose: register port host that issues reads and writes
// Assumes: called just after a rising edge of ref_clk
// Notes:   idle address and data show the inverse of the last value
module reg_host_model
	import adc_irq_pkg::*;
(
	input  wire logic              ref_clk,
	output logic     [ADDR_W-1:0]  regAddr,
	output logic                   regWrEn,
	output logic                   regRdEn,
	output logic     [REG_W-1:0]   regWrData,
	input  wire logic [REG_W-1:0]  regRdData,
	input  wire logic              regRdValid
);
	timeunit 1ns;
	timeprecision 100ps;

	initial begin
		regAddr = 8'h00;
		regWrEn = 1'b0;
		regRdEn = 1'b0;
		regWrData = 16'h0000;
	end

	// ==========================================================
	// accesses
	// a trailing idle edge keeps strobes of back-to-back calls apart
	task automatic regWrite(input logic [ADDR_W-1:0] a,
		input logic [REG_W-1:0] d);
		regAddr = a;
		regWrData = d;
		regWrEn = 1'b1;
		@(posedge ref_clk);
		#1;
		regWrEn = 1'b0;
		regAddr = ~a;
		regWrData = ~d;
		@(posedge ref_clk);
		#1;
	endtask

	task automatic regRead(input logic [ADDR_W-1:0] a,
		output logic [REG_W-1:0] d, output bit ok);
		int i;
		regAddr = a;
		regRdEn = 1'b1;
		@(posedge ref_clk);
		#1;
		regRdEn = 1'b0;
		regAddr = ~a;
		i = 0;
		while (regRdValid !== 1'b1 && i < 4) begin
			@(posedge ref_clk);
			#1;
			i++;
		end
		ok = (regRdValid === 1'b1);
		d = regRdData;
		@(posedge ref_clk);
		#1;
	endtask
endmodule // reg_host_model

// ==== tb/test_adc_event_interrupt_regs.sv ====
// Purpose: self-checking bench for the event flag and enable registers
// Assumes: inputs change 1 ns after the rising edge
// Notes:   each event is fired once with its enable off, once on
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_fail++; \
	$display("MISMATCH %s exp %h got %h", nm, e, g); end end

module test_adc_event_interrupt_regs
	import adc_irq_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;

	logic                ref_clk = 1'b0;
	logic                srst = 1'b1;
	logic [ADDR_W-1:0]   regAddr;
	logic                regWrEn;
	logic                regRdEn;
	logic [REG_W-1:0]    regWrData;
	logic [REG_W-1:0]    regRdData;
	logic                regRdValid;
	logic [4:0]          evt = 5'h00;
	logic [NUM_COMP-1:0] pin = 4'h0;
	logic                irqOut;
	int                  n_fail = 0;
	int                  n_checks = 0;
	logic [REG_W-1:0]    bitV;

	always #25 ref_clk = ~ref_clk;

	reg_host_model i_reg_host_model (.ref_clk(ref_clk), .regAddr(regAddr),
		.regWrEn(regWrEn), .regRdEn(regRdEn), .regWrData(regWrData),
		.regRdData(regRdData), .regRdValid(regRdValid));

	adc_event_interrupt_regs i_adc_event_interrupt_regs (.ref_clk(ref_clk),
		.srst(srst), .regAddr(regAddr), .regWrEn(regWrEn),
		.regRdEn(regRdEn), .regWrData(regWrData), .regRdData(regRdData),
		.regRdValid(regRdValid), .cycleDone(evt[4]), .convFault(evt[3]),
		.fieldLoss(evt[2]), .frameError(evt[1]), .checksumError(evt[0]),
		.thresholdOutputPin(pin), .irqOut(irqOut));

	// ==========================================================
	// helpers
	task automatic stop_test();
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	task automatic cyc(input int n);
		repeat (n) begin
			@(posedge ref_clk);
			#1;
		end
	endtask

	task automatic rdChk(input logic [ADDR_W-1:0] a,
		input logic [REG_W-1:0] e, input string nm);
		logic [REG_W-1:0] d;
		bit               ok;
		i_reg_host_model.regRead(a, d, ok);
		if (!ok) begin
			n_fail++;
			$display("MISMATCH %s exp %h got %h", nm, 1'b1, ok);
			stop_test();
		end
		`CHK(nm, e, d)
	endtask

	// pulse inputs for bits 12..8, pin edges for 7..0
	task automatic fire(input int b);
		if (b >= 8) begin
			evt[b-8] = 1'b1;
			cyc(1);
			evt[b-8] = 1'b0;
		end else begin
			pin[b%4] = (b >= 4);
			cyc(1);
		end
	endtask

	// ==========================================================
	// sequence
	initial begin
		cyc(20);
		srst = 1'b0;
		rdChk(ADDR_INTERRUPT_FLAGS, 16'h0000, "flagsRst");
		rdChk(ADDR_INTERRUPT_MASK, 16'h0000, "maskRst");
		`CHK("irqRst", 1'b0, irqOut)
		i_reg_host_model.regWrite(ADDR_INTERRUPT_MASK, 16'hFFFF);
		rdChk(ADDR_INTERRUPT_MASK, 16'h1FFF, "maskRw");
		i_reg_host_model.regWrite(ADDR_INTERRUPT_FLAGS, 16'hFFFF);
		rdChk(ADDR_INTERRUPT_FLAGS, 16'h0000, "flagsRo");
		rdChk(8'h20, 16'h0000, "unmapped");
		$display("test registers done");

		// other enables on while this one is off, so leaks show
		for (int en = 0; en < 2; en++) begin
			for (int b = 12; b >= 0; b--) begin
				bitV = 16'h0001 << b;
				i_reg_host_model.regWrite(ADDR_INTERRUPT_MASK,
					(en == 1) ? bitV : (16'h1FFF & ~bitV));
				fire(b);
				`CHK("irqLag", 1'b0, irqOut)
				cyc(1);
				`CHK("irq", en[0], irqOut)
				cyc(1);
				`CHK("irqHold", en[0], irqOut)
				rdChk(ADDR_INTERRUPT_FLAGS, bitV, "flag");
				`CHK("irqClr", 1'b0, irqOut)
				rdChk(ADDR_INTERRUPT_FLAGS, 16'h0000, "clr");
			end
		end
		rdChk(ADDR_INTERRUPT_FLAGS, 16'h0000, "noEdge");
		$display("test events done");

		// event in the clearing cycle survives the clear
		fork
			rdChk(ADDR_INTERRUPT_FLAGS, 16'h0000, "preEvt");
			fire(9);
		join
		rdChk(ADDR_INTERRUPT_FLAGS, 16'h0200, "setWins");
		$display("test set wins done");

		i_reg_host_model.regWrite(ADDR_INTERRUPT_MASK, 16'h1FFF);
		fire(12);
		cyc(1);
		`CHK("irqPreRst", 1'b1, irqOut)
		srst = 1'b1;
		cyc(2);
		srst = 1'b0;
		`CHK("irqRst2", 1'b0, irqOut)
		rdChk(ADDR_INTERRUPT_FLAGS, 16'h0000, "flagsRst2");
		rdChk(ADDR_INTERRUPT_MASK, 16'h0000, "maskRst2");
		$display("test second reset done");
		stop_test();
	end

	initial begin
		#4000000;
		n_fail++;
		$display("MISMATCH run time limit exp end got hang");
		stop_test();
	end
endmodule // test_adc_event_interrupt_regs
